/* File: rtl/cdc_pkg.sv */
package cdc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int NREG = 8;

   localparam logic [6:0] ADDR_SOFT_RESET_AND_IDENT = 7'h00;
   localparam logic [6:0] ADDR_POWER_MANAGEMENT_ONE = 7'h01;
   localparam logic [6:0] ADDR_INPUT_ROUTING_CONTROL = 7'h2C;
   localparam logic [6:0] ADDR_INPUT_GAIN_CONTROL = 7'h2D;
   localparam logic [6:0] ADDR_ADC_BOOST_CONTROL = 7'h2F;
   localparam logic [6:0] ADDR_OUTPUT_CONTROL = 7'h31;
   localparam logic [6:0] ADDR_SPEAKER_MIXER_CONTROL = 7'h32;
   localparam logic [6:0] ADDR_SPEAKER_VOLUME_CONTROL = 7'h36;
   localparam logic [6:0] ADDR_MONO_MIXER_CONTROL = 7'h38;

   // Stored registers, in slot order 0..NREG-1
   localparam logic [6:0] REG_ADDR [NREG] = '{
      ADDR_POWER_MANAGEMENT_ONE, ADDR_INPUT_ROUTING_CONTROL,
      ADDR_INPUT_GAIN_CONTROL, ADDR_ADC_BOOST_CONTROL,
      ADDR_OUTPUT_CONTROL, ADDR_SPEAKER_MIXER_CONTROL,
      ADDR_SPEAKER_VOLUME_CONTROL, ADDR_MONO_MIXER_CONTROL};

   // Writable bits per slot; all others read as zero, except the revision field of slot 0
   localparam logic [15:0] REG_MASK [NREG] = '{
      16'h01F8, 16'h010F, 16'h00FF, 16'h0100,
      16'h0003, 16'h0023, 16'h01FF, 16'h00C7};

   // Values after reset per slot
   localparam logic [15:0] REG_RESET [NREG] = '{
      16'h0000, 16'h0002, 16'h0050, 16'h0000,
      16'h0002, 16'h0000, 16'h0079, 16'h0000};

   // Read-only revision field in the power register
   localparam int REV_LSB = 0;
   localparam int REV_W = 3;

   // ----------------------------------------------------------------
   // Control word carried to the analogue section
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ref_free_bias_enable;
      logic level_shifter_enable;
      logic aux_buffer_enable;
      logic loop_synth_enable;
      logic mic_bias_enable;
      logic amp_bias_enable;
      logic mic_bias_level_select;
      logic aux_input_mode;
      logic aux_to_input_amp;
      logic mic_neg_to_input_amp;
      logic mic_pos_to_input_amp;
      logic input_amp_zero_cross;
      logic input_amp_silence;
      logic [5:0] input_amp_gain;
      logic input_amp_boost;
      logic thermal_shutdown_enable;
      logic out_ref_select;
      logic aux_to_speaker;
      logic bypass_to_speaker;
      logic playback_to_speaker;
      logic speaker_attenuate;
      logic speaker_zero_cross;
      logic speaker_silence;
      logic [5:0] speaker_gain;
      logic line_out_attenuate;
      logic line_out_silence;
      logic aux_to_line_out;
      logic bypass_to_line_out;
      logic playback_to_line_out;
   } cdc_ctrl_t;

endpackage

/* File: rtl/cdc_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module cdc_regs #(
   parameter logic [15:0] PART_IDENT = 16'h5A5A, // Arbitrary value
   parameter logic [2:0] SILICON_REV = 3'h0
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [cdc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [cdc_pkg::DATA_W-1:0] reg_wdata,
   output logic [cdc_pkg::DATA_W-1:0] reg_rdata,
   output cdc_pkg::cdc_ctrl_t ctrl
);
   import cdc_pkg::*;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [15:0] regs [NREG];
   logic [NREG-1:0] hit;
   logic [15:0] rd_terms [NREG];
   logic [15:0] rd_or;
   logic soft_reset;
   logic [15:0] next_rdata;

   // Write to address zero carries no data, only the reset action
   assign soft_reset = reg_wr && (reg_addr == ADDR_SOFT_RESET_AND_IDENT);

   // ----------------------------------------------------------------
   // Register slots
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_slot
         assign hit[gi] = (reg_addr == REG_ADDR[gi]);
         assign rd_terms[gi] = hit[gi] ? regs[gi] : 16'h0000;
         // Store masked data, reserved bits forced to zero
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               regs[gi] <= REG_RESET[gi];
            end else if (clk_en) begin
               if (soft_reset) begin
                  regs[gi] <= REG_RESET[gi];
               end else if (reg_wr && hit[gi]) begin
                  regs[gi] <= reg_wdata & REG_MASK[gi];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // OR of the selected slot; only one slot can match
   always_comb begin
      rd_or = 16'h0000;
      for (int i = 0; i < NREG; i++) begin
         rd_or = rd_or | rd_terms[i];
      end
   end

   // Identity at zero, revision merged into the power register
   always_comb begin
      next_rdata = rd_or;
      if (reg_addr == ADDR_SOFT_RESET_AND_IDENT) begin
         next_rdata = PART_IDENT;
      end else if (reg_addr == ADDR_POWER_MANAGEMENT_ONE) begin
         next_rdata[REV_LSB +: REV_W] = SILICON_REV;
      end
   end

   // Read data is held until the next read
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   // Power management: slot 0
   assign ctrl.ref_free_bias_enable = regs[0][8];
   assign ctrl.level_shifter_enable = regs[0][7];
   assign ctrl.aux_buffer_enable = regs[0][6];
   assign ctrl.loop_synth_enable = regs[0][5];
   assign ctrl.mic_bias_enable = regs[0][4];
   assign ctrl.amp_bias_enable = regs[0][3];
   // Input routing: slot 1
   assign ctrl.mic_bias_level_select = regs[1][8];
   assign ctrl.aux_input_mode = regs[1][3];
   assign ctrl.aux_to_input_amp = regs[1][2];
   assign ctrl.mic_neg_to_input_amp = regs[1][1];
   assign ctrl.mic_pos_to_input_amp = regs[1][0];
   // Input gain: slot 2
   assign ctrl.input_amp_zero_cross = regs[2][7];
   assign ctrl.input_amp_silence = regs[2][6];
   assign ctrl.input_amp_gain = regs[2][5:0];
   // Boost and output: slots 3 and 4
   assign ctrl.input_amp_boost = regs[3][8];
   assign ctrl.thermal_shutdown_enable = regs[4][1];
   assign ctrl.out_ref_select = regs[4][0];
   // Speaker mixer and volume: slots 5 and 6
   assign ctrl.aux_to_speaker = regs[5][5];
   assign ctrl.bypass_to_speaker = regs[5][1];
   assign ctrl.playback_to_speaker = regs[5][0];
   assign ctrl.speaker_attenuate = regs[6][8];
   assign ctrl.speaker_zero_cross = regs[6][7];
   assign ctrl.speaker_silence = regs[6][6];
   assign ctrl.speaker_gain = regs[6][5:0];
   // Line-out mixer: slot 7
   assign ctrl.line_out_attenuate = regs[7][7];
   assign ctrl.line_out_silence = regs[7][6];
   assign ctrl.aux_to_line_out = regs[7][2];
   assign ctrl.bypass_to_line_out = regs[7][1];
   assign ctrl.playback_to_line_out = regs[7][0];

endmodule

`default_nettype wire

/* File: tb/cdc_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module cdc_regs_properties #(
   parameter logic [15:0] PART_IDENT = 16'h5A5A,
   parameter logic [2:0] SILICON_REV = 3'h0
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire cdc_pkg::cdc_ctrl_t ctrl
);
   import cdc_pkg::*;
   // Taken requests
   wire wr_on = clk_en && reg_wr;
   wire wr_pw = wr_on && reg_addr == 7'h01;
   wire rd_on = clk_en && reg_rd;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_bit(q, int b);
      wr_pw |=> q == $past(reg_wdata[b]);
   endproperty
   a_soft_reset: assert property (wr_on && reg_addr == 7'h00 |=>
      ctrl.speaker_gain == 6'h39 && ctrl.input_amp_gain == 6'h10)
      else $error("soft reset");
   a_ident_read: assert property (rd_on && reg_addr == 7'h00 |=>
      reg_rdata == PART_IDENT) else $error("ident read");
   a_ref_bias: assert property (p_bit(ctrl.ref_free_bias_enable, 8))
      else $error("ref bias");
   a_lvl_shift: assert property (p_bit(ctrl.level_shifter_enable, 7))
      else $error("level shift");
   a_aux_buf: assert property (p_bit(ctrl.aux_buffer_enable, 6))
      else $error("aux buffer");
   a_mic_bias: assert property (p_bit(ctrl.mic_bias_enable, 4))
      else $error("mic bias");
   a_amp_bias: assert property (p_bit(ctrl.amp_bias_enable, 3))
      else $error("amp bias");
   a_rev_field: assert property (rd_on && reg_addr == 7'h01 |=>
      reg_rdata[2:0] == SILICON_REV) else $error("revision");
   a_mix_src: assert property (wr_on && reg_addr == 7'h32 |=>
      ctrl.aux_to_speaker == $past(reg_wdata[5])) else $error("mixer");
   // Main scenarios seen
   c_soft: cover property (wr_on && reg_addr == 7'h00);
   c_pwr: cover property (wr_pw);
   c_ident: cover property (rd_on && reg_addr == 7'h00);
endmodule
`default_nettype wire

/* File: tb/cdc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module cdc_host (
   input wire logic clk_sys,
   input wire logic [15:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [6:0] reg_addr,
   output logic [15:0] reg_wdata
);
   // Idle port
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 16'h0000;
   end
   // One write, held to the taking edge
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d; // Callers may set reserved bits; the register masks them off
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // One read; data stands from the taking edge, picked up at the next
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_cdc_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_cdc_regs;
   import cdc_pkg::*;
   localparam logic [15:0] PART_IDENT = 16'h1234; // Arbitrary value
   localparam logic [2:0] SILICON_REV = 3'h0;
   logic clk_sys, reset_n, clk_en, reg_wr, reg_rd;
   logic [6:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   cdc_ctrl_t ctrl;
   int failures, tests_run, cycles;
   cdc_regs #(.PART_IDENT(PART_IDENT), .SILICON_REV(SILICON_REV)) i_cdc_regs (
      .clk_sys, .reset_n, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .ctrl);
   cdc_host i_cdc_host (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata);
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task rdc(input string n, input logic [6:0] a, input logic [15:0] e);
      i_cdc_host.rd(a, d);
      chk(n, e, d);
   endtask
   function logic [15:0] pwr();
      return {11'h0, ctrl.ref_free_bias_enable, ctrl.level_shifter_enable,
         ctrl.aux_buffer_enable, ctrl.mic_bias_enable, ctrl.amp_bias_enable};
   endfunction
   task t_defaults;
      rdc("pwr", 7'h01, {13'h0, SILICON_REV});
      rdc("spk_mix", 7'h32, 16'h0000);
      rdc("mono_mix", 7'h38, 16'h0000);
      rdc("in_route", 7'h2C, 16'h0002);
      rdc("in_gain", 7'h2D, 16'h0050);
      rdc("out_ctl", 7'h31, 16'h0002);
      rdc("unmapped", 7'h30, 16'h0000);
      $display("defaults done");
   endtask
   task t_freeze;
      clk_en <= 1'b0;
      i_cdc_host.wr(7'h36, 16'h0001);
      i_cdc_host.wr(7'h00, 16'h0000);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      rdc("frozen_vol", 7'h36, 16'h0079);
      i_cdc_host.wr(7'h2C, 16'hFFFF);
      rdc("route_mask", 7'h2C, 16'h010F);
      $display("freeze done");
   endtask
   task t_power;
      i_cdc_host.wr(7'h01, 16'h0100);
      #1 chk("bias_first", 16'h0010, pwr());
      i_cdc_host.wr(7'h01, 16'h01DF);
      #1 chk("pwr_on", 16'h001F, pwr());
      rdc("pwr_rd", 7'h01, {13'h003B, SILICON_REV});
      i_cdc_host.wr(7'h01, 16'h0008);
      #1 chk("pwr_off", 16'h0001, pwr());
      $display("power done");
   endtask
   task t_mixer;
      i_cdc_host.wr(7'h32, 16'h0023);
      i_cdc_host.wr(7'h38, 16'h0006);
      #1 chk("mix", 16'h0076, {9'h0, ctrl.aux_to_speaker,
         ctrl.bypass_to_speaker, ctrl.playback_to_speaker, 1'b0,
         ctrl.aux_to_line_out, ctrl.bypass_to_line_out,
         ctrl.playback_to_line_out});
      $display("mixer done");
   endtask
   task t_soft;
      i_cdc_host.wr(7'h36, 16'h003F);
      i_cdc_host.wr(7'h00, 16'hFFFF);
      rdc("vol", 7'h36, 16'h0079);
      rdc("pwr_rst", 7'h01, {13'h0, SILICON_REV});
      rdc("mix_rst", 7'h32, 16'h0000);
      rdc("ident", 7'h00, PART_IDENT);
      $display("soft reset done");
   endtask
   task summarize;
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      failures = 0;
      tests_run = 0;
      cycles = 0;
      reset_n = 1'b0;
      clk_en = 1'b1;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_defaults();
      t_power();
      t_mixer();
      t_soft();
      t_freeze();
      summarize();
   end
endmodule
bind cdc_regs cdc_regs_properties #(.PART_IDENT(PART_IDENT),
   .SILICON_REV(SILICON_REV)) i_cdc_regs_properties (.clk_sys, .reset_n,
   .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .ctrl);
`default_nettype wire
